// ### cnm_pkg.sv
// cnm_pkg: constants, types and helpers of the nmt slave node monitor
package cnm_pkg;

  // ***************************************************************
  // frame identifiers, lengths and command specifiers
  // ***************************************************************
  localparam logic [10:0] CNM_ID_NMT     = 11'h000;
  localparam logic [10:0] CNM_ID_HB_BASE = 11'h700;
  localparam logic [10:0] CNM_ID_EM_BASE = 11'h080;
  localparam logic [3:0]  CNM_NMT_DLC    = 4'h2;
  localparam logic [3:0]  CNM_STAT_DLC   = 4'h1;
  localparam logic [3:0]  CNM_EMCY_DLC   = 4'h8;
  localparam logic [7:0]  CNM_CS_START   = 8'h01;
  localparam logic [7:0]  CNM_CS_STOP    = 8'h02;
  localparam logic [7:0]  CNM_CS_PREOP   = 8'h80;
  localparam logic [7:0]  CNM_CS_RSTNODE = 8'h81;
  localparam logic [7:0]  CNM_CS_RSTCOMM = 8'h82;
  localparam logic [7:0]  CNM_ADDR_ALL   = 8'h00;

  // ***************************************************************
  // state codes, error codes and reaction selectors
  // ***************************************************************
  localparam logic [6:0]  CNM_CODE_BOOT  = 7'h00;
  localparam logic [6:0]  CNM_CODE_STOP  = 7'h04;
  localparam logic [6:0]  CNM_CODE_OP    = 7'h05;
  localparam logic [6:0]  CNM_CODE_PREOP = 7'h7F;
  localparam logic [15:0] CNM_EMCY_MON   = 16'h8130;
  localparam logic [15:0] CNM_MFR_MON    = 16'h0100;
  localparam logic [7:0]  CNM_EREG_COMM  = 8'h10;
  localparam logic [31:0] CNM_ABORT_NOACC = 32'h08000020;
  localparam logic [1:0]  CNM_REACT_PREOP = 2'h0;
  localparam logic [1:0]  CNM_REACT_STOP  = 2'h2;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CNM_CLK_NS    = 100;
  localparam int CNM_MS_NS     = 1000000;
  localparam int CNM_MS_CYCLES = (CNM_MS_NS + CNM_CLK_NS - 1) / CNM_CLK_NS;
  localparam logic [2:0] CNM_INIT_LAST = 3'h3;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {CNM_INIT, CNM_PREOP, CNM_OP, CNM_STOPPED}
    cnm_state_t;
  typedef enum logic [1:0] {MON_NONE, MON_GUARD, MON_PROD, MON_CONS}
    cnm_mon_t;
  typedef enum logic [1:0] {TX_BOOT, TX_EMCY, TX_GUARD, TX_HB} cnm_tx_t;

  // identifier of a node-relative object
  function automatic logic [10:0] cnm_cob_id(input logic [10:0] base,
                                             input logic [6:0]  node);
    cnm_cob_id = base + {4'h0, node};
  endfunction : cnm_cob_id

  // state code reported in guarding and heartbeat frames
  function automatic logic [6:0] cnm_code(input cnm_state_t st);
    case (st)
      CNM_OP:      cnm_code = CNM_CODE_OP;
      CNM_STOPPED: cnm_code = CNM_CODE_STOP;
      CNM_PREOP:   cnm_code = CNM_CODE_PREOP;
      default:     cnm_code = CNM_CODE_BOOT;
    endcase
  endfunction : cnm_code

endpackage : cnm_pkg

// ### cnm_tmr_if.sv
// cnm_tmr_if: link between node monitor control and its ms timer
interface cnm_tmr_if;
  logic        load;     // restart with period
  logic [23:0] period;   // timeout in ms, zero clears
  logic        run;      // low holds timer cleared
  logic        expired;  // one-cycle pulse at timeout

  modport ctrl (output load, period, run, input expired);
  modport tmr  (input load, period, run, output expired);
endinterface : cnm_tmr_if

// ### cnm_mon_timer.sv
// cnm_mon_timer: millisecond prescaler and monitoring timeout counter
module cnm_mon_timer #(
  parameter int MS_CYCLES = cnm_pkg::CNM_MS_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // control side
  cnm_tmr_if.tmr    tmr
);
  import cnm_pkg::*;

  localparam logic [15:0] PRE_LAST = 16'(MS_CYCLES - 1);

  logic [15:0] pre_reg;
  logic [23:0] remain_reg;
  logic        tick;

  assign tick = (pre_reg == PRE_LAST);

  // ***************************************************************
  // prescaler, restarted with every load
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || tmr.load || !tmr.run || tick) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  // remaining ms, stops at zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !tmr.run) begin
      remain_reg <= 24'h000000;
    end else if (tmr.load) begin
      remain_reg <= tmr.period;
    end else if (tick && remain_reg != 24'h000000) begin
      remain_reg <= remain_reg - 24'h000001;
    end
  end

  // timeout pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tmr.expired <= 1'b0;
    end else begin
      tmr.expired <= tmr.run && !tmr.load && tick &&
                     (remain_reg == 24'h000001);
    end
  end

endmodule : cnm_mon_timer

// ### cnm_nmt_node.sv
// cnm_nmt_node: nmt slave state machine, boot-up, guarding, heartbeat
// Behaviour
// - leave initialisation into pre-operational unaided
// - pre-operational: no pdo, only nmt and sdo
// - start command 0x01 enters operational, pdo on
// - 0x80 enters pre-operational, pdo off, sdo on
// - 0x02 stops: sdo, pdo off, nmt only
// - 0x81 full node reset, then reinitialise
// - 0x82 resets communication part only
// - nmt frame id 0, cs, address; 0=all
// - serious comm error falls back, reaction selectable
// - boot-up frame 0x700+id, one byte zero
// - only one monitoring scheme active at once
// - answer guarding remote request with state, toggle
// - toggle starts 0, flips each guard answer
// - codes 04 stopped, 05 operational, 7F pre-op
// - heartbeat boot code 00, top bit zero
// - missing guard request in life time errors
// - producer heartbeat periodic, guard time forced zero
// - boot-up frame counts as first heartbeat
// - consumer time nonzero: consume, producer ignored
// - missing master heartbeat raises heartbeat event
// - guard time write refused while producing heartbeat
// - emergency eight bytes at 0x80+id, tail zero
// - monitoring timeout sets 0x0100 in error word
module cnm_nmt_node #(
  parameter int MS_CYCLES = cnm_pkg::CNM_MS_CYCLES
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // node configuration
  input  wire logic [6:0]          node_id_i,
  input  wire logic [7:0]          life_factor_i,
  input  wire logic [15:0]         prod_hb_ms_i,
  input  wire logic [15:0]         cons_hb_ms_i,
  input  wire logic [6:0]          cons_node_i,
  input  wire logic [15:0]         emcy_mask_i,
  input  wire logic [1:0]          err_react_i,
  input  wire logic                comm_err_i,
  // guard time write port
  input  wire logic                gt_wr_i,
  input  wire logic [15:0]         gt_data_i,
  output logic                     gt_ack_o,
  output logic                     gt_abort_o,
  output logic [31:0]              abort_code_o,
  // received frames
  input  wire logic                rx_valid_i,
  input  wire logic [10:0]         rx_id_i,
  input  wire logic                rx_rtr_i,
  input  wire logic [3:0]          rx_dlc_i,
  input  wire logic [63:0]         rx_data_i,
  // frames to send
  output logic                     tx_valid_o,
  input  wire logic                tx_ready_i,
  output logic [10:0]              tx_id_o,
  output logic [3:0]               tx_dlc_o,
  output logic [63:0]              tx_data_o,
  // node status
  output cnm_pkg::cnm_state_t      nmt_state_o,
  output logic                     pdo_en_o,
  output logic                     sdo_en_o,
  output logic                     reset_app_o,
  output logic                     reset_comm_o,
  output logic                     mon_err_o,
  output logic [15:0]              mfr_err_o,
  output logic [7:0]               err_reg_o
);
  import cnm_pkg::*;

  // ***************************************************************
  // declarations
  // ***************************************************************
  cnm_state_t  state_reg, state_next;
  cnm_mon_t    mode_reg, mode_now;
  cnm_tx_t     kind_reg, sel;
  logic [2:0]  init_cnt_reg;
  logic [15:0] guard_reg;
  logic        toggle_reg;
  logic        boot_pend, emcy_pend, guard_pend, hb_pend;
  logic        nmt_hit, guard_req, hb_rx, prod_on, mon_err, prod_due;
  logic        comm_rst, node_rst, tx_done, any_pend, serious;
  logic [7:0]  cs, addr;
  logic [6:0]  code;
  cnm_tmr_if   tmr_bus ();

  cnm_mon_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tmr       (tmr_bus.tmr)
  );

  // ***************************************************************
  // frame decoding
  // ***************************************************************
  assign cs   = rx_data_i[7:0];
  assign addr = rx_data_i[15:8];
  assign nmt_hit = rx_valid_i && !rx_rtr_i && (rx_id_i == CNM_ID_NMT) &&
                   (rx_dlc_i == CNM_NMT_DLC) && (state_reg != CNM_INIT) &&
                   (addr == CNM_ADDR_ALL || addr == {1'b0, node_id_i});
  assign guard_req = rx_valid_i && rx_rtr_i && (state_reg != CNM_INIT) &&
                     (rx_id_i == cnm_cob_id(CNM_ID_HB_BASE, node_id_i)) &&
                     (mode_reg != MON_PROD) && (mode_reg != MON_CONS);
  assign hb_rx = rx_valid_i && !rx_rtr_i && (rx_dlc_i != 4'h0) &&
                 (mode_reg == MON_CONS) &&
                 (rx_id_i == cnm_cob_id(CNM_ID_HB_BASE, cons_node_i));
  assign node_rst = nmt_hit && (cs == CNM_CS_RSTNODE);
  assign comm_rst = node_rst || (nmt_hit && cs == CNM_CS_RSTCOMM);
  assign prod_on  = (prod_hb_ms_i != 16'h0000);
  assign code     = cnm_code(state_reg);

  // monitoring scheme selection, consumer first
  always_comb begin
    if (cons_hb_ms_i != 16'h0000) begin
      mode_now = MON_CONS;
    end else if (prod_on) begin
      mode_now = MON_PROD;
    end else if (guard_reg != 16'h0000 && life_factor_i != 8'h00) begin
      mode_now = MON_GUARD;
    end else begin
      mode_now = MON_NONE;
    end
  end

  // ***************************************************************
  // node state machine
  // ***************************************************************
  assign serious = comm_err_i || mon_err;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CNM_INIT: begin
        if (init_cnt_reg == CNM_INIT_LAST) begin
          state_next = CNM_PREOP;
        end
      end
      default: begin
        if (nmt_hit) begin
          case (cs)
            CNM_CS_START:   state_next = CNM_OP;
            CNM_CS_PREOP:   state_next = CNM_PREOP;
            CNM_CS_STOP:    state_next = CNM_STOPPED;
            CNM_CS_RSTNODE: state_next = CNM_INIT;
            CNM_CS_RSTCOMM: state_next = CNM_INIT;
            default:        state_next = state_reg;
          endcase
        end else if (serious && err_react_i == CNM_REACT_PREOP &&
                     state_reg == CNM_OP) begin
          state_next = CNM_PREOP;
        end else if (serious && err_react_i == CNM_REACT_STOP) begin
          state_next = CNM_STOPPED;
        end
      end
    endcase
  end

  // state register and service enables
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= CNM_INIT;
      nmt_state_o <= CNM_INIT;
      pdo_en_o  <= 1'b0;
      sdo_en_o  <= 1'b0;
    end else begin
      state_reg <= state_next;
      nmt_state_o <= state_next; // registered copy of the node state
      pdo_en_o  <= (state_next == CNM_OP);
      sdo_en_o  <= (state_next == CNM_OP) || (state_next == CNM_PREOP);
    end
  end

  // initialisation delay
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_reg != CNM_INIT) begin
      init_cnt_reg <= 3'h0;
    end else begin
      init_cnt_reg <= init_cnt_reg + 3'h1;
    end
  end

  // reset pulses toward application and communication objects
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reset_app_o  <= 1'b0;
      reset_comm_o <= 1'b0;
    end else begin
      reset_app_o  <= node_rst;
      reset_comm_o <= comm_rst;
    end
  end

  // ***************************************************************
  // guard time object and its write port
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || comm_rst || prod_on) begin
      guard_reg <= 16'h0000;
    end else if (gt_wr_i) begin
      guard_reg <= gt_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gt_ack_o     <= 1'b0;
      gt_abort_o   <= 1'b0;
      abort_code_o <= 32'h00000000;
    end else begin
      gt_ack_o   <= gt_wr_i && !prod_on;
      gt_abort_o <= gt_wr_i && prod_on;
      if (gt_wr_i) begin
        abort_code_o <= prod_on ? CNM_ABORT_NOACC : 32'h00000000;
      end
    end
  end

  // ***************************************************************
  // monitoring timer control
  // ***************************************************************
  assign tx_done  = tx_valid_o && tx_ready_i;
  assign prod_due = tmr_bus.expired && (mode_reg == MON_PROD);
  assign mon_err  = tmr_bus.expired &&
                    (mode_reg == MON_GUARD || mode_reg == MON_CONS);
  assign tmr_bus.run  = (state_reg != CNM_INIT) && (mode_reg != MON_NONE);
  assign tmr_bus.load = (mode_now != mode_reg) ||
                        (mode_reg == MON_GUARD && guard_req) ||
                        (mode_reg == MON_CONS && hb_rx) ||
                        (mode_reg == MON_PROD && tx_done &&
                         (kind_reg == TX_BOOT || kind_reg == TX_HB));
  always_comb begin
    if (mode_now != mode_reg) begin
      tmr_bus.period = 24'h000000;
    end else if (mode_reg == MON_GUARD) begin
      tmr_bus.period = 24'(guard_reg) * 24'(life_factor_i);
    end else if (mode_reg == MON_CONS) begin
      tmr_bus.period = {8'h00, cons_hb_ms_i};
    end else begin
      tmr_bus.period = {8'h00, prod_hb_ms_i};
    end
  end

  // active scheme, one at a time
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_reg <= MON_NONE;
    end else begin
      mode_reg <= mode_now;
    end
  end

  // error word, error register and error pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || node_rst) begin
      mfr_err_o <= 16'h0000;
      err_reg_o <= 8'h00;
      mon_err_o <= 1'b0;
    end else begin
      mon_err_o <= mon_err;
      if (mon_err) begin
        mfr_err_o <= mfr_err_o | CNM_MFR_MON;
        err_reg_o <= CNM_EREG_COMM;
      end
    end
  end

  // ***************************************************************
  // transmit requests, set wins over take
  // ***************************************************************
  assign any_pend = boot_pend || emcy_pend || guard_pend || hb_pend;
  always_comb begin
    if (boot_pend) begin
      sel = TX_BOOT;
    end else if (emcy_pend) begin
      sel = TX_EMCY;
    end else if (guard_pend) begin
      sel = TX_GUARD;
    end else begin
      sel = TX_HB;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || comm_rst) begin
      boot_pend  <= 1'b0;
      emcy_pend  <= 1'b0;
      guard_pend <= 1'b0;
      hb_pend    <= 1'b0;
    end else begin
      boot_pend  <= (state_reg == CNM_INIT && state_next == CNM_PREOP) ||
                    (boot_pend && !(!tx_valid_o && sel == TX_BOOT));
      emcy_pend  <= (mon_err && (emcy_mask_i & CNM_MFR_MON) != 16'h0000) ||
                    (emcy_pend && !(!tx_valid_o && sel == TX_EMCY));
      guard_pend <= guard_req ||
                    (guard_pend && !(!tx_valid_o && sel == TX_GUARD));
      hb_pend    <= prod_due ||
                    (hb_pend && !(!tx_valid_o && sel == TX_HB));
    end
  end

  // ***************************************************************
  // transmit frame register
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || comm_rst) begin
      tx_valid_o <= 1'b0;
      tx_id_o    <= 11'h000;
      tx_dlc_o   <= 4'h0;
      tx_data_o  <= 64'h0000000000000000;
      kind_reg   <= TX_BOOT;
    end else if (tx_done) begin
      tx_valid_o <= 1'b0;
    end else if (!tx_valid_o && any_pend) begin
      tx_valid_o <= 1'b1;
      kind_reg   <= sel;
      case (sel)
        TX_BOOT: begin
          tx_id_o   <= cnm_cob_id(CNM_ID_HB_BASE, node_id_i);
          tx_dlc_o  <= CNM_STAT_DLC;
          tx_data_o <= {56'h0, 1'b0, CNM_CODE_BOOT};
        end
        TX_EMCY: begin
          tx_id_o   <= cnm_cob_id(CNM_ID_EM_BASE, node_id_i);
          tx_dlc_o  <= CNM_EMCY_DLC;
          tx_data_o <= {24'h0, mfr_err_o, err_reg_o, CNM_EMCY_MON};
        end
        TX_GUARD: begin
          tx_id_o   <= cnm_cob_id(CNM_ID_HB_BASE, node_id_i);
          tx_dlc_o  <= CNM_STAT_DLC;
          tx_data_o <= {56'h0, toggle_reg, code};
        end
        default: begin
          tx_id_o   <= cnm_cob_id(CNM_ID_HB_BASE, node_id_i);
          tx_dlc_o  <= CNM_STAT_DLC;
          tx_data_o <= {56'h0, 1'b0, code};
        end
      endcase
    end
  end

  // guarding toggle, flips once per guard answer sent
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || comm_rst) begin
      toggle_reg <= 1'b0;
    end else if (tx_done && kind_reg == TX_GUARD) begin
      toggle_reg <= !toggle_reg;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_init_exit;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == CNM_INIT && init_cnt_reg == CNM_INIT_LAST) |=>
      (state_reg == CNM_PREOP) ##1 (tx_valid_o && kind_reg == TX_BOOT);
  endproperty
  a_init_exit: assert property (p_init_exit)
    else $error("init did not end in pre-operational with boot-up");

  property p_preop_nopdo;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == CNM_PREOP) |-> (!pdo_en_o && sdo_en_o);
  endproperty
  a_preop_nopdo: assert property (p_preop_nopdo)
    else $error("pdo enabled in pre-operational");

  property p_start;
    @(posedge clk_sys_i) disable iff (rst_i)
    (nmt_hit && cs == CNM_CS_START) |=> (state_reg == CNM_OP && pdo_en_o);
  endproperty
  a_start: assert property (p_start)
    else $error("start command did not reach operational");

  property p_stop;
    @(posedge clk_sys_i) disable iff (rst_i)
    (nmt_hit && cs == CNM_CS_STOP) |=> (!sdo_en_o && !pdo_en_o);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop command left services enabled");

  property p_rstnode;
    @(posedge clk_sys_i) disable iff (rst_i)
    node_rst |=> (reset_app_o && reset_comm_o && state_reg == CNM_INIT);
  endproperty
  a_rstnode: assert property (p_rstnode)
    else $error("node reset not carried out");

  property p_toggle;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tx_done && kind_reg == TX_GUARD && !comm_rst) |=>
      (toggle_reg != $past(toggle_reg));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("guard toggle did not flip");

  property p_refuse;
    @(posedge clk_sys_i) disable iff (rst_i)
    (gt_wr_i && prod_on) |=>
      (gt_abort_o && !gt_ack_o && abort_code_o == CNM_ABORT_NOACC &&
       guard_reg == 16'h0000);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("guard time write not refused");

  property p_emcy;
    @(posedge clk_sys_i) disable iff (rst_i)
    (tx_valid_o && kind_reg == TX_EMCY) |->
      (tx_dlc_o == CNM_EMCY_DLC && tx_data_o[63:40] == 24'h0 &&
       tx_data_o[15:0] == CNM_EMCY_MON &&
       tx_id_o == cnm_cob_id(CNM_ID_EM_BASE, node_id_i));
  endproperty
  a_emcy: assert property (p_emcy)
    else $error("emergency frame malformed");

  property p_foreign;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rx_valid_i && rx_id_i == CNM_ID_NMT && !rx_rtr_i &&
     addr != CNM_ADDR_ALL && addr != {1'b0, node_id_i} && !serious &&
     state_reg != CNM_INIT) |=> $stable(state_reg);
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("state changed on foreign nmt frame");

  property p_monbit;
    @(posedge clk_sys_i) disable iff (rst_i)
    (mon_err && !node_rst) |=> (mfr_err_o[8] && mon_err_o);
  endproperty
  a_monbit: assert property (p_monbit)
    else $error("monitoring error bit not set");

  c_start: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    nmt_hit && cs == CNM_CS_START);
  c_guard: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_done && kind_reg == TX_GUARD);
  c_hb: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_done && kind_reg == TX_HB);
  c_emcy: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_done && kind_reg == TX_EMCY);

endmodule : cnm_nmt_node

// ### cnm_mst_model.sv
// cnm_mst_model: network master model that sends and takes frames
module cnm_mst_model (
  // clock
  input  wire logic        clk_sys_i,
  // frames to the node
  output logic             rx_valid_o,
  output logic [10:0]      rx_id_o,
  output logic             rx_rtr_o,
  output logic [3:0]       rx_dlc_o,
  output logic [63:0]      rx_data_o,
  // frames from the node
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [3:0]  tx_dlc_i,
  input  wire logic [63:0] tx_data_i
);
  logic [10:0] got_id = 11'h7FF;
  logic [3:0]  got_dlc = 4'h0;
  logic [63:0] got_data = 64'h0;
  int          n_got = 0;

  // idle bus after power-up
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o    = 11'h7FF;
    rx_rtr_o   = 1'b0;
    rx_dlc_o   = 4'h0;
    rx_data_o  = 64'h0;
    tx_ready_o = 1'b0;
  end

  // one frame for one cycle; payload inverted once released
  task automatic send(input logic [10:0] id, input logic rtr,
                      input logic [15:0] pay);
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b1;
    rx_id_o    <= id;
    rx_rtr_o   <= rtr;
    rx_dlc_o   <= rtr ? 4'h0 : 4'h2;
    rx_data_o  <= {48'h0, pay};
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~rx_data_o;
  endtask : send

  // take node frames, every other one with a stalling ready
  always @(posedge clk_sys_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_id   <= tx_id_i;
      got_dlc  <= tx_dlc_i;
      got_data <= tx_data_i;
      n_got    <= n_got + 1;
    end
    tx_ready_o <= n_got[0] ? ~tx_ready_o : 1'b1;
  end
endmodule : cnm_mst_model

// ### cnm_nmt_node_bench.sv
// cnm_nmt_node_bench: self-checking bench of the nmt slave node
module cnm_nmt_node_bench import cnm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 4;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, comm_err = 1'b0, gt_wr = 1'b0;
  logic [7:0] life = 8'h01;
  logic [15:0] prod = 16'h0, gt_data = 16'h0, cons = 16'h0;
  logic [1:0] react = CNM_REACT_PREOP;
  logic gt_ack, gt_abort, rxv, rxrtr, txv, txr, pdo, sdo, r_app, r_comm;
  logic [31:0] abort_code;
  logic [10:0] rxid, txid;
  logic [3:0] rxdlc, txdlc;
  logic [63:0] rxd, txd;
  logic [15:0] mfr;
  logic [7:0] ereg;
  logic merr;
  cnm_state_t st;
  logic [7:0] cs_t [5] = '{8'h01, 8'h02, 8'h01, 8'h33, 8'h80};
  logic [7:0] ad_t [5] = '{8'h05, 8'h00, 8'h09, 8'h05, 8'h05};
  logic [4:0] pdo_x = 5'b00001, sdo_x = 5'b10001;
  int n_fail = 0;
  int samples_checked = 0;
  int n_merr = 0;
  time t0;

  cnm_nmt_node #(.MS_CYCLES(MS)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .node_id_i(7'h05),
    .life_factor_i(life), .prod_hb_ms_i(prod), .cons_hb_ms_i(cons),
    .cons_node_i(7'h01), .emcy_mask_i(16'hFFFF), .err_react_i(react),
    .comm_err_i(comm_err), .gt_wr_i(gt_wr), .gt_data_i(gt_data),
    .gt_ack_o(gt_ack), .gt_abort_o(gt_abort), .abort_code_o(abort_code),
    .rx_valid_i(rxv), .rx_id_i(rxid), .rx_rtr_i(rxrtr), .rx_dlc_i(rxdlc),
    .rx_data_i(rxd), .tx_valid_o(txv), .tx_ready_i(txr), .tx_id_o(txid),
    .tx_dlc_o(txdlc), .tx_data_o(txd), .nmt_state_o(st), .pdo_en_o(pdo),
    .sdo_en_o(sdo), .reset_app_o(r_app), .reset_comm_o(r_comm),
    .mon_err_o(merr), .mfr_err_o(mfr), .err_reg_o(ereg));
  cnm_mst_model u_mst (.clk_sys_i(clk_sys_i), .rx_valid_o(rxv),
    .rx_id_o(rxid), .rx_rtr_o(rxrtr), .rx_dlc_o(rxdlc), .rx_data_o(rxd),
    .tx_valid_i(txv), .tx_ready_o(txr), .tx_id_i(txid), .tx_dlc_i(txdlc),
    .tx_data_i(txd));

  // 10 MHz clock
  always #50 clk_sys_i = ~clk_sys_i;

  // count monitoring error pulses
  always @(posedge clk_sys_i) if (merr === 1'b1) n_merr++;

  // compare and count
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // wait for a node frame with the given identifier
  task automatic take(input logic [10:0] id);
    int n;
    n = u_mst.n_got;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (u_mst.n_got != n && u_mst.got_id === id) return;
      n = u_mst.n_got;
    end
    chk("frame id", 64'h0, {53'h0, id});
  endtask : take

  // nmt command, settled on the same edge that takes it
  task automatic nmt(input logic [7:0] cs, input logic [7:0] ad);
    u_mst.send(CNM_ID_NMT, 1'b0, {ad, cs});
    #1;
  endtask : nmt

  // guard time write strobe
  task automatic gt_put(input logic [15:0] d);
    @(posedge clk_sys_i);
    gt_wr   <= 1'b1;
    gt_data <= d;
    @(posedge clk_sys_i);
    gt_wr   <= 1'b0;
    #1;
  endtask : gt_put

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    results();
  end

  // test sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    take(11'h705);
    chk("boot dlc", u_mst.got_dlc, 4'h1);
    chk("boot byte", u_mst.got_data[7:0], 8'h00);
    chk("pdo", pdo, 1'b0);
    chk("sdo", sdo, 1'b1);
    chk("state", st, CNM_PREOP);
    foreach (cs_t[i]) begin
      nmt(cs_t[i], ad_t[i]);
      chk("pdo", pdo, pdo_x[i]);
      chk("sdo", sdo, sdo_x[i]);
    end
    nmt(CNM_CS_START, 8'h00);
    @(posedge clk_sys_i);
    comm_err <= 1'b1;
    @(posedge clk_sys_i);
    comm_err <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("pdo", pdo, 1'b0);
    chk("sdo", sdo, 1'b1);
    nmt(CNM_CS_RSTCOMM, 8'h05);
    chk("comm reset", r_comm, 1'b1);
    chk("app reset", r_app, 1'b0);
    take(11'h705);
    nmt(CNM_CS_RSTNODE, 8'h00);
    chk("app reset", r_app, 1'b1);
    take(11'h705);
    chk("sdo", sdo, 1'b1);
    for (int i = 0; i < 4; i++) begin
      if (i >= 2) nmt(i == 2 ? CNM_CS_START : CNM_CS_STOP, 8'h05);
      u_mst.send(11'h705, 1'b1, 16'h0000);
      take(11'h705);
      chk("guard", u_mst.got_data[7:0], {i[0], i < 2 ? CNM_CODE_PREOP :
          i == 2 ? CNM_CODE_OP : CNM_CODE_STOP});
    end
    nmt(CNM_CS_PREOP, 8'h05);
    gt_put(16'h0001);
    chk("ack", gt_ack, 1'b1);
    chk("abort code", abort_code, 32'h0);
    u_mst.send(11'h705, 1'b1, 16'h0000);
    take(11'h085);
    chk("emcy dlc", u_mst.got_dlc, 4'h8);
    chk("emcy", u_mst.got_data, 64'h0000000100108130);
    chk("mfr", mfr, CNM_MFR_MON);
    chk("err reg", ereg, CNM_EREG_COMM);
    chk("mon err", n_merr, 1);
    gt_put(16'h0000);
    prod <= 16'h0001;
    gt_put(16'h0002);
    chk("abort", gt_abort, 1'b1);
    chk("abort code", abort_code, CNM_ABORT_NOACC);
    nmt(CNM_CS_RSTCOMM, 8'h05);
    take(11'h705);
    t0 = $time;
    take(11'h705);
    chk("heartbeat", u_mst.got_data[7:0], {1'b0, CNM_CODE_PREOP});
    chk("hb gap", ($time - t0 >= MS * 100) && ($time - t0 <= (MS + 8) * 100),
        1'b1);
    cons <= 16'h0002;
    u_mst.send(11'h701, 1'b0, 16'h0005);
    repeat (4) @(posedge clk_sys_i);
    u_mst.send(11'h701, 1'b0, 16'h0005);
    t0 = $time;
    chk("mon err", n_merr, 1);
    take(11'h085);
    chk("hb lost", $time - t0 >= 2 * MS * 100, 1'b1);
    chk("mon err", n_merr, 2);
    results();
  end
endmodule : cnm_nmt_node_bench
